/* window_detector_pkg.sv */
// Constants, types and register map of the converter window detector.
// Assumes a 125 MHz pclk and an APB master with 32-bit data.
// Overview of operation
// - Compare every new result against both limits
// - Match flag raises interrupt and reads in control
// - Less-than above greater-than: flag inside window
// - Greater-than above less-than: flag outside window
// - Single-ended results compare as unsigned numbers
// - Differential results compare as signed numbers
// - Differential compare uses full 16-bit words, sign-extended only when right-justified
// - Limits compare against the justified result word
// - Limits are readable byte pairs; less-than resets zero
// - Conversion lasts ten SAR clocks, SAR clock limited
// - Match flag sticky until software clears it
// - Ground negative input means single-ended mode
// - Justify bit selects right or left placement
package window_detector_pkg;

    localparam int ADDR_W = 12;
    localparam int CODE_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_NEG_SEL = 8'hBA;
    localparam logic [7:0] IDX_CFG = 8'hBC;
    localparam logic [7:0] IDX_RES_L = 8'hBD;
    localparam logic [7:0] IDX_RES_H = 8'hBE;
    localparam logic [7:0] IDX_GT_L = 8'hC3;
    localparam logic [7:0] IDX_GT_H = 8'hC4;
    localparam logic [7:0] IDX_LT_L = 8'hC5;
    localparam logic [7:0] IDX_LT_H = 8'hC6;
    localparam logic [7:0] IDX_CTRL = 8'hE8;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hF0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hF1;

    // Control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_DONE_BIT = 5;
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_WIN_BIT = 3;
    // Configuration register field
    localparam int CFG_LJST_BIT = 2;
    // Interrupt status and mask fields
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_WIN_BIT = 1;
    localparam int IRQ_W = 2;

    // Negative input select
    localparam logic [4:0] NEG_SEL_GND = 5'h11;
    localparam logic [4:0] NEG_SEL_RESET = 5'h1F;

    // Reset values
    localparam logic [15:0] GT_RESET = 16'h0000;
    localparam logic [15:0] LT_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;

    // Timing: SAR clock at most 3 MHz, conversion ten SAR clocks
    localparam int PCLK_KHZ = 125000;
    localparam int SAR_MAX_KHZ = 3000;
    localparam int SAR_DIV = (PCLK_KHZ + SAR_MAX_KHZ - 1) / SAR_MAX_KHZ;
    localparam int CONV_SAR_CLKS = 10;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] CONV_CYCLES = CNT_W'(CONV_SAR_CLKS * SAR_DIV);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage

/* window_compare.sv */
// Window comparison of one result word against two limits.
// Assumes all inputs are stable registers in the caller's domain.
`timescale 1ns/1ps
module window_compare (
    input wire logic [15:0] result,
    input wire logic [15:0] gt_limit,
    input wire logic [15:0] lt_limit,
    input wire logic signed_mode,
    output logic match
);
    logic [15:0] r_b;
    logic [15:0] gt_b;
    logic [15:0] lt_b;
    logic inside_mode;

    // Flipping the top bit maps two's complement order onto unsigned
    always_comb begin
        r_b = result;
        gt_b = gt_limit;
        lt_b = lt_limit;
        if (signed_mode) begin
            r_b[15] = ~result[15];
            gt_b[15] = ~gt_limit[15];
            lt_b[15] = ~lt_limit[15];
        end // otherwise plain unsigned
    end

    // Limit order picks inside or outside detection
    always_comb begin
        inside_mode = lt_b > gt_b;
        if (inside_mode) begin
            match = (r_b > gt_b) && (r_b < lt_b);
        end else begin
            match = (r_b < lt_b) || (r_b > gt_b);
        end
    end
endmodule // window_compare

/* window_detector.sv */
// Converter sequencer, result registers and window detector with APB.
// Assumes sample_code is held stable by the analog core during conversion
// and is read only at the end of the conversion time.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module window_detector (
    input wire logic pclk,
    input wire logic presetn,
    input window_detector_pkg::apb_req_t apb_req,
    output window_detector_pkg::apb_rsp_t apb_rsp,
    input wire logic [window_detector_pkg::CODE_W-1:0] sample_code,
    output logic converter_enable,
    output logic conv_active,
    output logic irq
);
    import window_detector_pkg::*;

    conv_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic en_r;
    logic done_flag_r;
    logic win_flag_r;
    logic ljst_r;
    logic [4:0] neg_sel_r;
    logic [15:0] gt_r;
    logic [15:0] lt_r;
    logic [15:0] result_r;
    logic [IRQ_W-1:0] mask_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    logic setup;
    logic wr;
    logic [7:0] idx;
    logic aligned;
    logic hit;
    logic [7:0] rd_val;
    logic [7:0] wbyte;
    logic wr_ctrl;
    logic wr_stat;
    logic conv_end;
    logic start;
    logic diff_mode;
    logic [15:0] new_word;
    logic match;
    logic done_clr;
    logic win_clr;
    logic [IRQ_W-1:0] status;

    // Bus phase decode
    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign idx = apb_req.paddr[9:2];
    assign aligned = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0);
    assign wbyte = apb_req.pwdata[7:0];
    assign wr_ctrl = wr && aligned && (idx == IDX_CTRL);
    assign wr_stat = wr && aligned && (idx == IDX_IRQ_STAT);

    assign status = {win_flag_r, done_flag_r};

    // Read mux; unused bits of each byte read as zero
    always_comb begin
        hit = aligned;
        rd_val = 8'h00;
        if (idx == IDX_NEG_SEL) begin
            rd_val = {3'h0, neg_sel_r};
        end else if (idx == IDX_CFG) begin
            rd_val[CFG_LJST_BIT] = ljst_r;
        end else if (idx == IDX_RES_L) begin
            rd_val = result_r[7:0];
        end else if (idx == IDX_RES_H) begin
            rd_val = result_r[15:8];
        end else if (idx == IDX_GT_L) begin
            rd_val = gt_r[7:0];
        end else if (idx == IDX_GT_H) begin
            rd_val = gt_r[15:8];
        end else if (idx == IDX_LT_L) begin
            rd_val = lt_r[7:0];
        end else if (idx == IDX_LT_H) begin
            rd_val = lt_r[15:8];
        end else if (idx == IDX_CTRL) begin
            rd_val[CTRL_EN_BIT] = en_r;
            rd_val[CTRL_DONE_BIT] = done_flag_r;
            rd_val[CTRL_BUSY_BIT] = (state_r == ST_CONV);
            rd_val[CTRL_WIN_BIT] = win_flag_r;
        end else if (idx == IDX_IRQ_STAT) begin
            rd_val = {6'h00, status};
        end else if (idx == IDX_IRQ_MASK) begin
            rd_val = {6'h00, mask_r};
        end else begin
            hit = 1'b0;
        end
    end

    // Read data and error are latched in the setup cycle so that
    // the access cycle answers from flops with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            // Refused reads return zero so stale register bytes never leak out
            prdata_r <= (apb_req.pwrite || !hit) ? 32'h0000_0000 : {24'h00_0000, rd_val};
            pslverr_r <= ~hit;
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = pslverr_r;
    assign apb_rsp.prdata = prdata_r;

    // Mode and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            ljst_r <= 1'b0;
            neg_sel_r <= NEG_SEL_RESET;
            mask_r <= MASK_RESET;
        end else if (wr && aligned) begin
            if (idx == IDX_CTRL) begin
                en_r <= wbyte[CTRL_EN_BIT];
            end else if (idx == IDX_CFG) begin
                ljst_r <= wbyte[CFG_LJST_BIT];
            end else if (idx == IDX_NEG_SEL) begin
                neg_sel_r <= wbyte[4:0];
            end else if (idx == IDX_IRQ_MASK) begin
                mask_r <= wbyte[IRQ_W-1:0];
            end
        end
    end

    // Limit bytes; software must load both halves of each limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gt_r <= GT_RESET;
            lt_r <= LT_RESET;
        end else if (wr && aligned) begin
            if (idx == IDX_GT_L) begin
                gt_r[7:0] <= wbyte;
            end else if (idx == IDX_GT_H) begin
                gt_r[15:8] <= wbyte;
            end else if (idx == IDX_LT_L) begin
                lt_r[7:0] <= wbyte;
            end else if (idx == IDX_LT_H) begin
                lt_r[15:8] <= wbyte;
            end
        end
    end

    // Start on a write of one to busy, with the enable bit set in the
    // same write; a start during a conversion is ignored
    assign start = wr_ctrl && wbyte[CTRL_BUSY_BIT] && wbyte[CTRL_EN_BIT];
    assign conv_end = (state_r == ST_CONV) && (cnt_r == CONV_CYCLES - 1'b1);

    // Conversion sequencer; clearing enable aborts without a result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                    if (start) begin
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    cnt_r <= cnt_r + 1'b1;
                    // Abort at the clearing write itself, so busy never outlives enable
                    if (!en_r || conv_end || (wr_ctrl && !wbyte[CTRL_EN_BIT])) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // Signedness follows the negative input choice
    assign diff_mode = (neg_sel_r != NEG_SEL_GND);

    // Result word as software will see it
    always_comb begin
        if (ljst_r) begin
            new_word = {sample_code, 6'h00};
        end else if (diff_mode) begin
            new_word = {{6{sample_code[CODE_W-1]}}, sample_code};
        end else begin
            new_word = {6'h00, sample_code};
        end
    end

    // Limits meet the word in its justified form, unscaled
    window_compare u_cmp (
        .result(new_word),
        .gt_limit(gt_r),
        .lt_limit(lt_r),
        .signed_mode(diff_mode),
        .match(match)
    );

    // Result register loads at conversion end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= 16'h0000;
        end else if (conv_end) begin
            result_r <= new_word;
        end
    end

    // Flags clear by writing zero in control or one in status
    assign done_clr = (wr_ctrl && !wbyte[CTRL_DONE_BIT])
        || (wr_stat && wbyte[IRQ_DONE_BIT]);
    assign win_clr = (wr_ctrl && !wbyte[CTRL_WIN_BIT])
        || (wr_stat && wbyte[IRQ_WIN_BIT]);

    // Sticky flags; a hardware set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_r <= 1'b0;
            win_flag_r <= 1'b0;
        end else begin
            if (conv_end) begin
                done_flag_r <= 1'b1;
            end else if (done_clr) begin
                done_flag_r <= 1'b0;
            end
            if (conv_end && match) begin
                win_flag_r <= 1'b1;
            end else if (win_clr) begin
                win_flag_r <= 1'b0;
            end
        end
    end

    // Level interrupt while any unmasked flag stands
    assign irq = |(status & mask_r);
    assign converter_enable = en_r;
    assign conv_active = (state_r == ST_CONV);

endmodule // window_detector

/* window_detector_assertions.sv */
// Checker of the window detector's port behaviour over time.
// Assumes binding to window_detector; sees only its ports.
`timescale 1ns/1ps
module window_detector_checker (
    input wire logic pclk,
    input wire logic presetn,
    input window_detector_pkg::apb_req_t apb_req,
    input window_detector_pkg::apb_rsp_t apb_rsp,
    input wire logic [window_detector_pkg::CODE_W-1:0] sample_code,
    input wire logic converter_enable,
    input wire logic conv_active,
    input wire logic irq
);
    import window_detector_pkg::*;
    logic [CNT_W-1:0] cnt_r;
    logic wr_any;
    logic wr_ctrl;
    // Write strobes as the design takes them
    assign wr_any = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign wr_ctrl = wr_any && apb_req.paddr == {2'h0, IDX_CTRL, 2'h0};
    // Cycles spent converting; still holds the count in the first idle cycle, then zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= conv_active ? cnt_r + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_start;
        wr_ctrl && apb_req.pwdata[7] && apb_req.pwdata[4] && !conv_active;
    endsequence
    sequence s_run;
        conv_active [*8];
    endsequence
    property p_start; s_start |=> s_run; endproperty
    property p_len; $fell(conv_active) && converter_enable |-> cnt_r == CONV_CYCLES; endproperty
    property p_cause; $rose(conv_active) |-> $past(wr_ctrl); endproperty
    property p_en; conv_active |-> converter_enable; endproperty
    property p_rise; $rose(irq) |-> $fell(conv_active) || $past(wr_any); endproperty
    property p_fall; $fell(irq) |-> $past(wr_any); endproperty
    property p_err;
        apb_req.psel && !apb_req.penable && apb_req.paddr[1:0] != 2'h0
            |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
    endproperty
    property p_byte; apb_rsp.prdata[31:8] == 24'h0; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    a_len: assert property (p_len) else $error("bad conversion length");
    a_cause: assert property (p_cause) else $error("conversion without start");
    a_en: assert property (p_en) else $error("converting while disabled");
    a_rise: assert property (p_rise) else $error("irq rose without cause");
    a_fall: assert property (p_fall) else $error("irq fell without write");
    a_err: assert property (p_err) else $error("unaligned access not refused");
    a_byte: assert property (p_byte) else $error("upper read bits set");
endmodule // window_detector_checker
bind window_detector window_detector_checker chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .sample_code(sample_code),
    .converter_enable(converter_enable), .conv_active(conv_active), .irq(irq));

/* testbench.sv */
// Self-checking bench: limits, conversions, window flag and irq over APB.
// Assumes the checker is bound to the design; pclk runs at 125 MHz.
`timescale 1ns/1ps
module testbench;
    import window_detector_pkg::*;
    `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
        $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
    logic pclk;
    logic presetn;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [CODE_W-1:0] code;
    logic act;
    logic en;
    logic irq;
    int err_count = 0;
    int check_count = 0;
    logic [15:0] seed = 16'hADBA;
    window_detector dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .sample_code(code), .converter_enable(en), .conv_active(act), .irq(irq));
    // Free-running 8 ns clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Repeatable pseudo-random source
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Result word as it lands in the result register pair
    function automatic logic [15:0] word(input logic [9:0] c, input logic sg, input logic lj);
        return lj ? {c, 6'h0} : sg ? {{6{c[9]}}, c} : {6'h0, c};
    endfunction
    function automatic logic hit(input logic [15:0] r, input logic sg, input logic [15:0] g,
            input logic [15:0] l);
        logic a;
        logic b;
        logic w;
        a = sg ? $signed(r) > $signed(g) : r > g;
        b = sg ? $signed(r) < $signed(l) : r < l;
        w = sg ? $signed(l) > $signed(g) : l > g;
        return w ? a && b : a || b;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic e);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            err_count++;
            final_report();
        end
        q = rsp.prdata[7:0];
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, {2'h0, i, 2'h0}, d, q, e);
    endtask
    task automatic rd(input logic [7:0] i, output logic [7:0] q);
        logic e;
        apb(1'b0, {2'h0, i, 2'h0}, 8'h0, q, e);
    endtask
    // Start with flags left alone, then wait for the end of conversion
    task automatic conv(input logic [9:0] c);
        int n;
        code <= c;
        wr(IDX_CTRL, 8'hB8);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((n < 2 || act === 1'b1) && n < 1000);
        if (n >= 1000) begin
            err_count++;
            final_report();
        end
    endtask
    initial begin
        logic [7:0] q;
        logic e;
        logic [15:0] g;
        logic [15:0] l;
        logic [15:0] r;
        logic [9:0] c;
        logic sg;
        logic lj;
        logic m;
        logic flag;
        req = '0;
        code = '0;
        presetn = 1'b0;
        flag = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and a refused unaligned read
        rd(IDX_LT_L, q); `CHK(q, 8'h00)
        rd(IDX_LT_H, q); `CHK(q, 8'h00)
        apb(1'b0, 12'h3A1, 8'h0, q, e); `CHK({e, q}, 9'h100)
        // First four passes are the inside/outside corners, then random
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            sg = i < 4 ? i[1] : seed[0];
            lj = i < 4 ? 1'b0 : seed[1];
            c = i < 4 ? {{3{seed[9]}}, seed[6:0]} : seed[15:6];
            c = i == 2 ? 10'h000 : c;
            g = i[1] ? 16'hFFFF : 16'h0040;
            l = i[1] ? 16'h0040 : 16'h0080;
            {g, l} = i[0] ? {l, g} : {g, l};
            g = i < 4 ? g : word(seed[11:2], sg, lj);
            seed = lfsr(seed);
            l = i < 4 ? l : word(seed[15:6], sg, lj);
            wr(IDX_NEG_SEL, sg ? 8'h00 : {3'h0, NEG_SEL_GND});
            wr(IDX_CFG, {5'h0, lj, 2'h0});
            wr(IDX_GT_L, g[7:0]);
            wr(IDX_GT_H, g[15:8]);
            wr(IDX_LT_L, l[7:0]);
            wr(IDX_LT_H, l[15:8]);
            wr(IDX_IRQ_MASK, {6'h0, seed[3:2]});
            if (seed[4]) begin
                wr(IDX_IRQ_STAT, 8'h03);
                flag = 1'b0;
            end
            rd(IDX_LT_H, q); `CHK(q, l[15:8])
            conv(c);
            r = word(c, sg, lj);
            m = hit(r, sg, g, l) | flag;
            flag = m;
            rd(IDX_CTRL, q); `CHK({q[5], q[3]}, {1'b1, m})
            rd(IDX_IRQ_STAT, q); `CHK(q[1:0], {m, 1'b1})
            `CHK(irq, |({m, 1'b1} & seed[3:2]))
            rd(IDX_RES_H, q); `CHK(q, r[15:8])
            rd(IDX_RES_L, q); `CHK(q, r[7:0])
        end
        // Abort mid-conversion: no new result, zero flag bits clear both flags
        code <= ~c;
        wr(IDX_CTRL, 8'hB8);
        repeat (20) @(posedge pclk);
        `CHK({act, en}, 2'b11)
        wr(IDX_CTRL, 8'h00);
        @(posedge pclk);
        `CHK({act, en, irq}, 3'b000)
        rd(IDX_CTRL, q); `CHK(q, 8'h00)
        rd(IDX_RES_H, q); `CHK(q, r[15:8])
        rd(IDX_RES_L, q); `CHK(q, r[7:0])
        final_report();
    end
endmodule // testbench
